/* File: core/smic_pkg.sv */
package smic_pkg;

  // ---------------------------------------------------------------
  // Source counts and indices
  // ---------------------------------------------------------------
  localparam int NMI_NUM = 7;
  localparam int IRQ_NUM = 13;

  // Non-maskable source positions
  localparam int NMI_TIMER_A = 0;
  localparam int NMI_TIMER_B = 1;
  localparam int NMI_TIMER_C = 2;
  localparam int NMI_DIV1K = 3;
  localparam int NMI_KEY = 4;
  localparam int EXTERNAL_NONMASKABLE_REQ = 5;
  localparam int NMI_ADC = 6;

  // Maskable source positions, level number is position plus one
  localparam int IRQ_TIMER_A = 0;
  localparam int IRQ_TIMER_B = 1;
  localparam int IRQ_TIMER_C = 2;
  localparam int IRQ_DIV1K = 3;
  localparam int IRQ_DIV4K = 4;
  localparam int IRQ_DIV256K = 5;
  localparam int IRQ_DIV2M = 6;
  localparam int IRQ_KEY = 7;
  localparam int EXTERNAL_MASKABLE_REQ = 8;
  localparam int IRQ_ADC = 9;
  localparam int IRQ_SOUND = 10;
  localparam int IRQ_SPI = 11;
  localparam int IRQ_SERIAL = 12;

  // Index code meaning no bit set
  localparam logic [3:0] IRQ_NONE = 4'hd;

  // ---------------------------------------------------------------
  // Clock divider taps (log2 of the division ratio)
  // ---------------------------------------------------------------
  localparam int DIV_WIDTH = 21;
  localparam int DIV1K_BITS = 10;
  localparam int DIV4K_BITS = 12;
  localparam int DIV256K_BITS = 18;
  localparam int DIV2M_BITS = 21;

  // ---------------------------------------------------------------
  // Values after reset
  // ---------------------------------------------------------------
  localparam logic [DIV_WIDTH-1:0] DIV_RST = 21'h000000;
  localparam logic [NMI_NUM-1:0] NMI_PEND_RST = 7'h00;
  localparam logic [IRQ_NUM-1:0] IRQ_PEND_RST = 13'h0000;
  localparam logic [7:0] WAKE_LATCH_RST = 8'h00;
  localparam logic [9:0] PIN_SYNC_RST = 10'h3ff;

  // Power state
  typedef enum logic {
    PWR_RUN,
    PWR_SLEEP
  } smic_pwr_e;

endpackage

/* File: core/smic_div_ticks.sv */
`timescale 1ns/1ns
`default_nettype none
module smic_div_ticks
  import smic_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // Periodic one-cycle ticks
  output logic div1kTick,
  output logic div4kTick,
  output logic div256kTick,
  output logic div2mTick
);

  // ---------------------------------------------------------------
  // Free running CPU clock divider
  // ---------------------------------------------------------------
  logic [DIV_WIDTH-1:0] divCnt_ff;

  // Counter wraps at two to the power of its width
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
      divCnt_ff <= DIV_RST;
    else
      divCnt_ff <= divCnt_ff + 21'h000001;
  end

  // Tick when all bits below a tap are ones
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      div1kTick <= 1'b0;
      div4kTick <= 1'b0;
      div256kTick <= 1'b0;
      div2mTick <= 1'b0;
    end
    else
    begin
      div1kTick <= &divCnt_ff[DIV1K_BITS-1:0];
      div4kTick <= &divCnt_ff[DIV4K_BITS-1:0];
      div256kTick <= &divCnt_ff[DIV256K_BITS-1:0];
      div2mTick <= &divCnt_ff[DIV2M_BITS-1:0];
    end
  end

endmodule
`default_nettype wire

/* File: core/smic_top.sv */
// Summary of operation
// - Thirteen maskable and seven non-maskable request lines are handled.
// - No maskable request preempts a non-maskable one in service.
// - Maskable service yields to any non-maskable or higher priority request.
// - Levels 1 to 13: timers, dividers, key, external, ADC, sound, SPI, serial.
// - Ticks come from CPU clock divided by 1024, 4096, 262144, 2097152.
// - Timers, 1024 tick, key, external and ADC also have non-maskable lines.
// - External request is a falling edge on the edge pin.
// - Optional RC oscillator: edge pin drives inverted feedback input.
// - Software latches port A, enables wake; mismatch raises key change.
// - In sleep, any enabled request or port A change wakes the clock.
// - After wake the core resumes at the instruction after sleep.
`timescale 1ns/1ns
`default_nettype none
module smic_top
  import smic_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // Peripheral event pulses, same clock
  input wire logic timerAEvt,
  input wire logic timerBEvt,
  input wire logic timerCEvt,
  input wire logic adcEvt,
  input wire logic sound_engine_req,
  input wire logic spiEvt,
  input wire logic one_wire_serial_req,
  // Pins
  input wire logic [7:0] wake_port,
  input wire logic ext_edge_pin,
  input wire logic feedback_input_pin,
  output logic extPinOut,
  output logic extPinOe,
  // Software control
  input wire logic [NMI_NUM-1:0] nmiEnable,
  input wire logic [IRQ_NUM-1:0] irqEnable,
  input wire logic [NMI_NUM-1:0] nmiClear,
  input wire logic [IRQ_NUM-1:0] irqClear,
  input wire logic wakeLatchWr,
  input wire logic keyWakeEn,
  input wire logic rcOscEn,
  input wire logic sleepCmd,
  // Core handshake
  input wire logic nmiAck,
  input wire logic nmiRet,
  input wire logic irqAck,
  input wire logic irqRet,
  output logic nmiReq,
  output logic irqReq,
  output logic [3:0] irqLevel,
  // Status
  output logic [NMI_NUM-1:0] nmiPending,
  output logic [IRQ_NUM-1:0] irqPending,
  output logic [7:0] wake_port_latch,
  output logic sysClkRun,
  output logic resumeNext
);

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  // Index of lowest set bit, IRQ_NONE when empty
  function automatic logic [3:0] lowestSet(input logic [IRQ_NUM-1:0] v);
    logic [3:0] idx;
    idx = IRQ_NONE;
    for (int i = IRQ_NUM - 1; i >= 0; i--)
      if (v[i])
        idx = 4'(i);
    return idx;
  endfunction

  logic div1kTick, div4kTick, div256kTick, div2mTick;
  logic [9:0] sync1_ff, sync2_ff, sync3_ff, pinStable_ff;
  logic extPrev_ff, extFall, keyMismatch;
  logic [NMI_NUM-1:0] nmiEvt, nxt_nmiPending;
  logic [IRQ_NUM-1:0] irqEvt, nxt_irqPending;
  logic nmiActive_ff;
  logic [IRQ_NUM-1:0] irqInSvc_ff, nxt_irqInSvc;
  logic [3:0] pendIdx, svcIdx;
  logic nmiGo, irqGo;
  smic_pwr_e pwr_ff;

  // ---------------------------------------------------------------
  // Divider ticks
  // ---------------------------------------------------------------
  smic_div_ticks u_div (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .div1kTick(div1kTick),
    .div4kTick(div4kTick),
    .div256kTick(div256kTick),
    .div2mTick(div2mTick)
  );

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  // Three stages; a bit is accepted when stages two and three agree
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      sync1_ff <= PIN_SYNC_RST;
      sync2_ff <= PIN_SYNC_RST;
      sync3_ff <= PIN_SYNC_RST;
      pinStable_ff <= PIN_SYNC_RST;
    end
    else
    begin
      sync1_ff <= {feedback_input_pin, ext_edge_pin, wake_port};
      sync2_ff <= sync1_ff;
      sync3_ff <= sync2_ff;
      pinStable_ff <= (sync2_ff & sync3_ff) |
                      (pinStable_ff & (sync2_ff ^ sync3_ff));
    end
  end

  // ---------------------------------------------------------------
  // External edge and RC feedback
  // ---------------------------------------------------------------
  // Previous accepted level of the edge pin
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
      extPrev_ff <= 1'b1;
    else
      extPrev_ff <= pinStable_ff[8];
  end

  assign extFall = extPrev_ff & ~pinStable_ff[8];

  // Edge pin drives the inverted feedback input in oscillator mode
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      extPinOut <= 1'b0;
      extPinOe <= 1'b0;
    end
    else
    begin
      extPinOut <= ~pinStable_ff[9];
      extPinOe <= rcOscEn;
    end
  end

  // ---------------------------------------------------------------
  // Key change detection
  // ---------------------------------------------------------------
  // Software snapshots the port before enabling key wake
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
      wake_port_latch <= WAKE_LATCH_RST;
    else if (wakeLatchWr)
      wake_port_latch <= pinStable_ff[7:0];
  end

  assign keyMismatch = keyWakeEn &&
                       (pinStable_ff[7:0] != wake_port_latch);

  // ---------------------------------------------------------------
  // Source assembly
  // ---------------------------------------------------------------
  // Non-maskable lines mirror part of the maskable ones
  assign nmiEvt = {adcEvt, extFall, keyMismatch, div1kTick,
                   timerCEvt, timerBEvt, timerAEvt};
  assign irqEvt = {one_wire_serial_req, spiEvt, sound_engine_req, adcEvt,
                   extFall, keyMismatch, div2mTick, div256kTick,
                   div4kTick, div1kTick, timerCEvt, timerBEvt,
                   timerAEvt};

  // ---------------------------------------------------------------
  // Pending flags
  // ---------------------------------------------------------------
  // Set wins over a clear in the same cycle
  assign nxt_nmiPending = (nmiPending & ~nmiClear) |
                          (nmiEvt & nmiEnable);
  assign nxt_irqPending = (irqPending & ~irqClear) |
                          (irqEvt & irqEnable);

  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      nmiPending <= NMI_PEND_RST;
      irqPending <= IRQ_PEND_RST;
    end
    else
    begin
      nmiPending <= nxt_nmiPending;
      irqPending <= nxt_irqPending;
    end
  end

  // ---------------------------------------------------------------
  // Priority and preemption
  // ---------------------------------------------------------------
  assign pendIdx = lowestSet(irqPending);
  assign svcIdx = lowestSet(irqInSvc_ff);
  assign nmiGo = (|nmiPending) && !nmiActive_ff;
  assign irqGo = (pendIdx != IRQ_NONE) && (pendIdx < svcIdx) &&
                 !nmiActive_ff && !nmiGo;

  // Registered request lines toward the core
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      nmiReq <= 1'b0;
      irqReq <= 1'b0;
      irqLevel <= 4'h0;
    end
    else
    begin
      nmiReq <= nmiGo;
      irqReq <= irqGo;
      irqLevel <= irqGo ? pendIdx + 4'h1 : 4'h0;
    end
  end

  // Non-maskable service marker
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
      nmiActive_ff <= 1'b0;
    else if (nmiAck && nmiReq)
      nmiActive_ff <= 1'b1;
    else if (nmiRet)
      nmiActive_ff <= 1'b0;
  end

  // Nested maskable levels; return closes the innermost level
  always_comb
  begin
    nxt_irqInSvc = irqInSvc_ff;
    if (irqRet)
      nxt_irqInSvc = irqInSvc_ff & (irqInSvc_ff - 13'h0001);
    if (irqAck && irqReq)
      nxt_irqInSvc = nxt_irqInSvc |
                     (13'h0001 << (irqLevel - 4'h1));
  end

  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
      irqInSvc_ff <= IRQ_PEND_RST;
    else
      irqInSvc_ff <= nxt_irqInSvc;
  end

  // ---------------------------------------------------------------
  // Sleep and wake
  // ---------------------------------------------------------------
  // Clock stops on the sleep command and restarts on any enabled request or key mismatch
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      pwr_ff <= PWR_RUN;
      sysClkRun <= 1'b1;
      resumeNext <= 1'b0;
    end
    else
    begin
      resumeNext <= 1'b0;
      unique case (pwr_ff)
        PWR_RUN:
        begin
          if (sleepCmd)
          begin
            pwr_ff <= PWR_SLEEP;
            sysClkRun <= 1'b0;
          end
        end
        PWR_SLEEP:
        begin
          if ((|nxt_nmiPending) || (|nxt_irqPending) || keyMismatch)
          begin
            pwr_ff <= PWR_RUN;
            sysClkRun <= 1'b1;
            resumeNext <= 1'b1;
          end
        end
      endcase
    end
  end

endmodule
`default_nettype wire

/* File: bench/smic_properties.sv */
`timescale 1ns/1ns
`default_nettype none
module smic_properties
  import smic_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // Inputs watched
  input wire logic timerAEvt,
  input wire logic ext_edge_pin,
  input wire logic feedback_input_pin,
  input wire logic [IRQ_NUM-1:0] irqEnable,
  input wire logic [NMI_NUM-1:0] nmiClear,
  input wire logic [IRQ_NUM-1:0] irqClear,
  input wire logic nmiAck,
  input wire logic nmiRet,
  input wire logic irqAck,
  input wire logic irqRet,
  input wire logic sleepCmd,
  // Outputs watched
  input wire logic nmiReq,
  input wire logic irqReq,
  input wire logic [3:0] irqLevel,
  input wire logic [NMI_NUM-1:0] nmiPending,
  input wire logic [IRQ_NUM-1:0] irqPending,
  input wire logic sysClkRun,
  input wire logic resumeNext,
  input wire logic extPinOut
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (sys_rst);

  // Steps of taking and servicing a request
  sequence s_itake;
    irqAck && irqReq && !irqRet;
  endsequence
  sequence s_quiet;
    !irqRet [*2];
  endsequence
  sequence s_ntake;
    nmiAck && nmiReq && !nmiRet;
  endsequence
  property p_nest;
    logic [3:0] lv;
    (s_itake, lv = irqLevel) ##1 s_quiet |-> !irqReq || irqLevel < lv;
  endproperty

  // Checks on the request outputs and flags
  AST_NMI_FIRST: assert property (nmiReq |-> !irqReq)
    else $error("maskable request shown beside non-maskable");
  AST_LEVEL_IDLE: assert property (!irqReq |-> irqLevel == 4'h0)
    else $error("level not zero while idle");
  AST_LOWEST: assert property (irqReq |-> ($past(irqPending) &
    ((13'h0001 << irqLevel) - 13'h0001)) == (13'h0001 << (irqLevel - 4'h1)))
    else $error("level is not lowest pending");
  AST_STICKY: assert property ((nmiPending & $past(nmiPending) &
    ~$past(nmiClear)) == ($past(nmiPending) & ~$past(nmiClear)))
    else $error("pending flag lost without clear");
  AST_SET: assert property (timerAEvt && irqEnable[0] |=> irqPending[0])
    else $error("enabled event not pended");
  AST_NO_SPURIOUS: assert property ($rose(irqPending[0]) |->
    $past(timerAEvt) && $past(irqEnable[0]))
    else $error("pending set without event");
  AST_NEST: assert property (p_nest)
    else $error("request not above level in service");
  AST_NMI_HOLD: assert property (s_ntake ##1 !nmiRet |=> !nmiReq)
    else $error("non-maskable request during its service");
  AST_SLEEP: assert property (sleepCmd && sysClkRun |=> !sysClkRun)
    else $error("sleep not entered");
  AST_WAKE: assert property (!sysClkRun && (irqPending & ~irqClear) !=
    13'h0000 |=> sysClkRun && resumeNext)
    else $error("pending request did not wake");
  AST_EXT: assert property ($fell(ext_edge_pin) && irqEnable[8] |->
    ##[3:6] irqPending[8])
    else $error("falling edge not pended");
  AST_FEEDBACK: assert property (!feedback_input_pin [*6] |-> extPinOut)
    else $error("feedback output not inverted");
endmodule
bind smic_top smic_properties u_props (.*);
`default_nettype wire

/* File: bench/smic_core_model.sv */
`timescale 1ns/1ns
`default_nettype none
module smic_core_model
  import smic_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // Requests from the controller
  input wire logic nmiReq,
  input wire logic irqReq,
  input wire logic [3:0] irqLevel,
  input wire logic [NMI_NUM-1:0] nmiPending,
  input wire logic [7:0] svcLat,
  // Handshake back
  output logic nmiAck,
  output logic nmiRet,
  output logic irqAck,
  output logic irqRet,
  output logic [NMI_NUM-1:0] svcNmiClr,
  output logic [IRQ_NUM-1:0] svcIrqClr
);
  logic [IRQ_NUM-1:0] stk_ff;
  logic busy_ff;
  logic [7:0] cnt_ff;
  logic [1:0] gap_ff;
  logic [1:0] ret_ff;

  // Take, wait, clear the flag, then return; stale requests skipped
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      {nmiAck, nmiRet, irqAck, irqRet} <= 4'h0;
      svcNmiClr <= 7'h00;
      svcIrqClr <= 13'h0000;
      stk_ff <= 13'h0000;
      busy_ff <= 1'b0;
      cnt_ff <= 8'h00;
      gap_ff <= 2'h0;
      ret_ff <= 2'h0;
    end
    else
    begin
      {nmiAck, nmiRet, irqAck, irqRet} <= 4'h0;
      svcNmiClr <= 7'h00;
      svcIrqClr <= 13'h0000;
      ret_ff <= 2'h0;
      gap_ff <= (gap_ff != 2'h0) ? gap_ff - 2'h1 : 2'h0;
      if (ret_ff[1])
      begin
        nmiRet <= 1'b1;
        busy_ff <= 1'b0;
      end
      else if (ret_ff[0])
      begin
        irqRet <= 1'b1; // Innermost level ends first
        stk_ff <= stk_ff & (stk_ff - 13'h0001);
      end
      else if (nmiReq && !busy_ff && gap_ff == 2'h0)
      begin
        nmiAck <= 1'b1; // Taken over any maskable service
        busy_ff <= 1'b1;
        cnt_ff <= svcLat;
        gap_ff <= 2'h3;
      end
      else if (irqReq && !busy_ff && gap_ff == 2'h0)
      begin
        irqAck <= 1'b1; // Nests inside higher-numbered levels
        stk_ff[irqLevel - 4'h1] <= 1'b1;
        cnt_ff <= svcLat;
        gap_ff <= 2'h3;
      end
      else if (cnt_ff != 8'h00)
        cnt_ff <= cnt_ff - 8'h01;
      else if (busy_ff)
      begin
        svcNmiClr <= nmiPending; // Flag cleared before return
        ret_ff <= 2'h2;
      end
      else if (stk_ff != 13'h0000)
      begin
        svcIrqClr <= stk_ff & (~stk_ff + 13'h0001);
        ret_ff <= 2'h1;
      end
    end
  end
endmodule
`default_nettype wire

/* File: bench/tb_top.sv */
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import smic_pkg::*;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  wire timerAEvt, timerBEvt, timerCEvt, adcEvt;
  wire sound_engine_req, spiEvt, one_wire_serial_req;
  logic [6:0] evt = 7'h00;
  logic [7:0] wake_port = 8'h00, svcLat = 8'h04;
  logic ext_edge_pin = 1'b1, feedback_input_pin = 1'b1, wakeLatchWr = 1'b0;
  logic keyWakeEn = 1'b0, rcOscEn = 1'b0, sleepCmd = 1'b0;
  logic [NMI_NUM-1:0] nmiEnable = 7'h00, nmiPending, svcNmiClr;
  logic [IRQ_NUM-1:0] irqEnable = 13'h0000, irqPending, svcIrqClr;
  wire [NMI_NUM-1:0] nmiClear;
  wire [IRQ_NUM-1:0] irqClear;
  logic nmiAck, nmiRet, irqAck, irqRet, nmiReq, irqReq;
  logic sysClkRun, resumeNext, extPinOut, extPinOe;
  logic [3:0] irqLevel;
  logic [7:0] wake_port_latch;
  logic [31:0] rs = 32'h0000f382;
  logic [6:0] m;
  int miscompares = 0, tests_run = 0, k, c, s, n;

  // Event lines and clears from the core model
  assign {one_wire_serial_req, spiEvt, sound_engine_req, adcEvt} = evt[6:3];
  assign {timerCEvt, timerBEvt, timerAEvt} = evt[2:0];
  assign irqClear = svcIrqClr;
  assign nmiClear = svcNmiClr;

  smic_top uut (.*);
  smic_core_model partner (.*);

  // Clock of 40 ns
  always #20 core_clk = ~core_clk;

  function automatic logic [31:0] xs(input logic [31:0] v);
    v = v ^ (v << 13);
    v = v ^ (v >> 17);
    v = v ^ (v << 5);
    return v;
  endfunction
  function automatic logic [12:0] irqBits(input logic [6:0] e);
    return {e[6:3], 6'h00, e[2:0]};
  endfunction
  function automatic logic [6:0] nmiBits(input logic [6:0] e);
    return {e[3], 3'h0, e[2:0]};
  endfunction
  function automatic logic [3:0] lowLvl(input logic [12:0] p);
    logic [3:0] r;
    r = 4'h0;
    for (int i = 12; i >= 0; i--)
      if (p[i])
        r = 4'(i + 1);
    return r;
  endfunction

  task automatic cyc(input int t);
    repeat (t) @(negedge core_clk);
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      $display("[FAIL] %0t seen %h want %h", $time, seen, exp);
      miscompares++;
    end
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic pulse(input logic [6:0] e);
    evt = e;
    cyc(1);
    evt = 7'h00;
  endtask
  task automatic limit(input int cnt, input int lim);
    if (cnt >= lim)
    begin
      $display("[FAIL] %0t wait ran out", $time);
      miscompares++;
      report_and_stop();
    end
  endtask
  task automatic waitAck;
    for (k = 0; k < 600 && irqAck !== 1'b1; k++)
      cyc(1);
    limit(k, 600);
  endtask
  task automatic drain;
    for (k = 0; k < 3000 &&
      {irqPending, nmiPending, irqReq, nmiReq} !== 22'h000000; k++)
      cyc(1);
    limit(k, 3000);
    cyc(4);
  endtask

  // Main sequence
  initial
  begin
    cyc(10);
    sys_rst = 1'b0;
    cyc(1);
    check({irqPending, nmiPending, irqReq, nmiReq, sysClkRun}, 23'h1);
    for (n = 0; n < 16; n++)
    begin
      rs = xs(rs);
      m = rs[6:0];
      irqEnable = irqBits(rs[13:7]);
      nmiEnable = nmiBits(rs[20:14]);
      svcLat = {4'h0, rs[24:21]} + 8'h04;
      cyc(1);
      pulse(m);
      check(irqPending, irqBits(m) & irqEnable);
      check(nmiPending, nmiBits(m) & nmiEnable);
      if ((irqBits(m) & irqEnable) != 13'h0000)
      begin
        for (k = 0; k < 600 && irqReq !== 1'b1; k++)
          cyc(1);
        limit(k, 600);
        check(irqLevel, lowLvl(irqBits(m) & irqEnable));
      end
      drain();
    end
    $display("test random mixes done");
    irqEnable = 13'h0201;
    nmiEnable = 7'h02;
    svcLat = 8'h3c;
    pulse(7'h08);
    waitAck();
    check(irqLevel, 4'ha);
    pulse(7'h01);
    waitAck();
    check({irqAck, irqLevel}, 5'h11);
    pulse(7'h02);
    for (k = 0; k < 8 && nmiReq !== 1'b1; k++)
      cyc(1);
    limit(k, 8);
    check(nmiReq, 1'b1);
    drain();
    $display("test preemption done");
    svcLat = 8'h04;
    for (s = 3; s < 5; s++)
    begin
      irqEnable = 13'h0001 << s;
      nmiEnable = (s == 3) ? 7'h08 : 7'h00;
      for (k = 0; k < 5000 && irqPending[s] !== 1'b1; k++)
        cyc(1);
      limit(k, 5000);
      check(nmiPending[3], s == 3);
      c = 0;
      while (c < 9000 && irqPending[s] === 1'b1)
      begin
        cyc(1);
        c++;
      end
      while (c < 9000 && irqPending[s] !== 1'b1)
      begin
        cyc(1);
        c++;
      end
      limit(c, 9000);
      check(c, (s == 3) ? 1024 : 4096);
      drain();
    end
    $display("test ticks done");
    irqEnable = 13'h0080;
    nmiEnable = 7'h00;
    svcLat = 8'h20;
    rs = xs(rs);
    wake_port = rs[7:0];
    cyc(5);
    wakeLatchWr = 1'b1;
    cyc(1);
    wakeLatchWr = 1'b0;
    cyc(1);
    check(wake_port_latch, rs[7:0]);
    keyWakeEn = 1'b1;
    sleepCmd = 1'b1;
    cyc(1);
    sleepCmd = 1'b0;
    cyc(20);
    check({sysClkRun, irqPending}, 14'h0000);
    wake_port = ~rs[7:0];
    for (k = 0; k < 10 && sysClkRun !== 1'b1; k++)
      cyc(1);
    limit(k, 10);
    check(resumeNext, 1'b1);
    cyc(2);
    check(irqPending[7], 1'b1);
    sleepCmd = 1'b1;
    cyc(1);
    sleepCmd = 1'b0;
    cyc(2);
    check(sysClkRun, 1'b1);
    wake_port = rs[7:0];
    keyWakeEn = 1'b0;
    drain();
    $display("test key and sleep done");
    irqEnable = 13'h0100;
    svcLat = 8'h08;
    ext_edge_pin = 1'b0;
    for (k = 0; k < 10 && irqPending[8] !== 1'b1; k++)
      cyc(1);
    limit(k, 10);
    check(irqPending[8], 1'b1);
    drain();
    ext_edge_pin = 1'b1;
    cyc(10);
    check(irqPending[8], 1'b0);
    rcOscEn = 1'b1;
    feedback_input_pin = 1'b0;
    cyc(6);
    check({extPinOe, extPinOut}, 2'h3);
    feedback_input_pin = 1'b1;
    cyc(6);
    check({extPinOe, extPinOut}, 2'h2);
    $display("test pins done");
    report_and_stop();
  end
endmodule
`default_nettype wire
